// ==== rtl/lfp_pkg.sv ====
package lfp_pkg;
    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFF_BAUD = 8'h10;
    // ==========================================================
    // control field positions
    localparam int CTRL_F2C = 0;
    localparam int CTRL_C2F = 1;
    localparam int CTRL_ECHO = 2;
    localparam int CTRL_AUTONEG = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // ==========================================================
    // event bits
    localparam int EV_FIBER_FAULT = 0;
    localparam int EV_COPPER_FAULT = 1;
    localparam int EV_FIBER_CLEAR = 2;
    localparam int EV_COPPER_CLEAR = 3;
    localparam int EV_W = 4;
    // ==========================================================
    // console timing: 20 MHz clock, 38400 baud
    localparam int CLK_HZ = 20000000;
    localparam int BAUD = 38400;
    localparam int BAUD_DIV = CLK_HZ / BAUD;
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
endpackage : lfp_pkg

// ==== rtl/fault_ctl_if.sv ====
`timescale 1ns/1ps
interface fault_ctl_if;
    logic f2c_en;
    logic c2f_en;
    logic echo_en;
    logic fiber_fault;
    logic copper_fault;
    logic fiber_rx_fault;
    logic copper_link_en;
    logic fiber_tx_en;
    modport ctl (input f2c_en, c2f_en, echo_en, fiber_fault,
        copper_fault, fiber_rx_fault, output copper_link_en, fiber_tx_en);
    modport top (output f2c_en, c2f_en, echo_en, fiber_fault,
        copper_fault, fiber_rx_fault, input copper_link_en, fiber_tx_en);
endinterface : fault_ctl_if

// ==== rtl/fault_forward.sv ====
`timescale 1ns/1ps
module fault_forward (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control interface
    fault_ctl_if.ctl fc
);
    typedef struct packed {
        logic copper_link_en;
        logic fiber_tx_en;
    } ff_state_t;
    ff_state_t s_r;
    ff_state_t s_nxt;
    // ==========================================================
    // forwarding decisions
    always_comb begin
        s_nxt = s_r;
        // copper kept up unless fiber fault is forwarded
        s_nxt.copper_link_en = !(fc.f2c_en && fc.fiber_fault);
        // transmitter off for forwarded copper fault or echoed rx fault
        s_nxt.fiber_tx_en = !((fc.c2f_en && fc.copper_fault)
            || (fc.echo_en && fc.fiber_rx_fault));
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '{copper_link_en: 1'b1, fiber_tx_en: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end
    assign fc.copper_link_en = s_r.copper_link_en;
    assign fc.fiber_tx_en = s_r.fiber_tx_en;
    // ==========================================================
    // checks
    copper_drop_a: assert property (@(posedge clk) disable iff (rst)
        fc.f2c_en && fc.fiber_fault |=> !fc.copper_link_en)
        else $error("copper link not dropped on fiber fault");
    copper_kept_a: assert property (@(posedge clk) disable iff (rst)
        !fc.f2c_en |=> fc.copper_link_en)
        else $error("copper link dropped while forwarding off");
    tx_off_a: assert property (@(posedge clk) disable iff (rst)
        fc.c2f_en && fc.copper_fault |=> !fc.fiber_tx_en)
        else $error("fiber tx not off on copper fault");
    echo_off_a: assert property (@(posedge clk) disable iff (rst)
        fc.echo_en && fc.fiber_rx_fault |=> !fc.fiber_tx_en)
        else $error("fiber tx not off on echoed rx fault");
    tx_restore_a: assert property (@(posedge clk) disable iff (rst)
        !(fc.c2f_en && fc.copper_fault) && !(fc.echo_en && fc.fiber_rx_fault)
        |=> fc.fiber_tx_en)
        else $error("fiber tx not restored");
endmodule : fault_forward

// ==== rtl/link_fault_propagation.sv ====
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
// Function
// - fiber fault forwarded drops copper link when enabled
// - forwarding off: fiber fault shown on fiber indicator only
// - copper fault turns fiber transmitter off when enabled
// - tx forced off with autoneg setting: fiber link indicator off
// - echo enabled: fiber receive fault turns fiber transmitter off
// - full pass-through: both forwardings enabled on both converters
// - console runs 38400 baud, 8 data, 1 stop, no parity
module link_fault_propagation (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // link status inputs
    input wire logic FIBER_FAULT,
    input wire logic FIBER_RX_FAULT,
    input wire logic COPPER_FAULT,
    // link controls and indicators
    output logic COPPER_LINK_EN,
    output logic FIBER_TX_EN,
    output logic FIBER_LINK_LED,
    output logic FIBER_FAULT_LED,
    // interrupt
    output logic IRQ
);
    typedef struct packed {
        logic [3:0] ctrl;
        logic [lfp_pkg::EV_W-1:0] irq_stat;
        logic [lfp_pkg::EV_W-1:0] irq_mask;
        logic fiber_fault_d;
        logic copper_fault_d;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic fiber_link_led;
        logic fiber_fault_led;
        logic irq;
    } top_state_t;
    top_state_t s_r;
    top_state_t s_nxt;
    fault_ctl_if fc ();
    // ==========================================================
    // forwarding core
    assign fc.f2c_en = s_r.ctrl[lfp_pkg::CTRL_F2C];
    assign fc.c2f_en = s_r.ctrl[lfp_pkg::CTRL_C2F];
    assign fc.echo_en = s_r.ctrl[lfp_pkg::CTRL_ECHO];
    assign fc.fiber_fault = FIBER_FAULT;
    assign fc.copper_fault = COPPER_FAULT;
    assign fc.fiber_rx_fault = FIBER_RX_FAULT;
    // both forwardings on at once give full pass-through
    fault_forward u_ff (
        .clk(CLK),
        .rst(RST),
        .fc(fc)
    );
    function automatic logic [31:0] zext4(input logic [3:0] v);
        zext4 = {28'h0000000, v};
    endfunction : zext4
    // ==========================================================
    // registers and indicators
    always_comb begin
        logic [lfp_pkg::EV_W-1:0] ev;
        logic wr;
        logic rd;
        logic tx_forced;
        ev = '0;
        wr = PSEL && PENABLE && PWRITE && !s_r.pready;
        rd = PSEL && PENABLE && !PWRITE && !s_r.pready;
        tx_forced = fc.c2f_en && COPPER_FAULT;
        s_nxt = s_r;
        s_nxt.fiber_fault_d = FIBER_FAULT;
        s_nxt.copper_fault_d = COPPER_FAULT;
        ev[lfp_pkg::EV_FIBER_FAULT] = FIBER_FAULT && !s_r.fiber_fault_d;
        ev[lfp_pkg::EV_COPPER_FAULT] = COPPER_FAULT && !s_r.copper_fault_d;
        ev[lfp_pkg::EV_FIBER_CLEAR] = !FIBER_FAULT && s_r.fiber_fault_d;
        ev[lfp_pkg::EV_COPPER_CLEAR] = !COPPER_FAULT && s_r.copper_fault_d;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (wr || rd) begin
            s_nxt.pready = 1'b1;
        end
        if (wr) begin
            case (PADDR)
                lfp_pkg::OFF_CTRL: s_nxt.ctrl = PWDATA[3:0];
                lfp_pkg::OFF_IRQ_STAT:
                    s_nxt.irq_stat = s_r.irq_stat & ~PWDATA[3:0];
                lfp_pkg::OFF_IRQ_MASK: s_nxt.irq_mask = PWDATA[3:0];
                lfp_pkg::OFF_STATUS, lfp_pkg::OFF_BAUD: ;
                default: s_nxt.pslverr = 1'b1;
            endcase
        end
        if (rd) begin
            case (PADDR)
                lfp_pkg::OFF_CTRL: s_nxt.prdata = zext4(s_r.ctrl);
                lfp_pkg::OFF_STATUS: s_nxt.prdata = zext4({
                    fc.fiber_tx_en, fc.copper_link_en,
                    COPPER_FAULT, FIBER_FAULT});
                lfp_pkg::OFF_IRQ_STAT: s_nxt.prdata = zext4(s_r.irq_stat);
                lfp_pkg::OFF_IRQ_MASK: s_nxt.prdata = zext4(s_r.irq_mask);
                // fixed console framing, read only
                lfp_pkg::OFF_BAUD: s_nxt.prdata = {
                    8'(lfp_pkg::DATA_BITS), 4'(lfp_pkg::STOP_BITS),
                    20'(lfp_pkg::BAUD)};
                default: begin
                    s_nxt.prdata = 32'h00000000;
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end
        // set wins over a same-cycle clear
        s_nxt.irq_stat = s_nxt.irq_stat | ev;
        // fault only on the fiber indicator when not forwarded
        s_nxt.fiber_fault_led = FIBER_FAULT || FIBER_RX_FAULT;
        // dark tx with autoneg: peer cannot negotiate, led off
        s_nxt.fiber_link_led = !FIBER_FAULT && !FIBER_RX_FAULT
            && !(tx_forced && s_r.ctrl[lfp_pkg::CTRL_AUTONEG]);
        s_nxt.irq = |(s_r.irq_stat & s_r.irq_mask);
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_r <= '{ctrl: lfp_pkg::CTRL_RESET, irq_stat: '0,
                irq_mask: '0, fiber_fault_d: 1'b0, copper_fault_d: 1'b0,
                prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0,
                fiber_link_led: 1'b0, fiber_fault_led: 1'b0, irq: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end
    assign PRDATA = s_r.prdata;
    assign PREADY = s_r.pready;
    assign PSLVERR = s_r.pslverr;
    assign COPPER_LINK_EN = fc.copper_link_en;
    assign FIBER_TX_EN = fc.fiber_tx_en;
    assign FIBER_LINK_LED = s_r.fiber_link_led;
    assign FIBER_FAULT_LED = s_r.fiber_fault_led;
    assign IRQ = s_r.irq;
    // ==========================================================
    // checks
    led_off_a: assert property (@(posedge CLK) disable iff (RST)
        s_r.ctrl[lfp_pkg::CTRL_C2F] && s_r.ctrl[lfp_pkg::CTRL_AUTONEG]
        && COPPER_FAULT |=> !FIBER_LINK_LED)
        else $error("fiber link led on while tx forced off");
    fault_led_a: assert property (@(posedge CLK) disable iff (RST)
        FIBER_FAULT |=> FIBER_FAULT_LED)
        else $error("fiber fault not indicated");
    copper_restore_a: assert property (@(posedge CLK)
        disable iff (RST)
        $fell(FIBER_FAULT) |-> ##[0:1] COPPER_LINK_EN)
        else $error("copper link not restored");
    irq_sticky_a: assert property (@(posedge CLK) disable iff (RST)
        $rose(FIBER_FAULT) |=> s_r.irq_stat[lfp_pkg::EV_FIBER_FAULT])
        else $error("fiber fault event lost");
    irq_out_a: assert property (@(posedge CLK) disable iff (RST)
        |(s_r.irq_stat & s_r.irq_mask) |=> IRQ)
        else $error("irq not raised");
    apb_ready_a: assert property (@(posedge CLK) disable iff (RST)
        PSEL && !PENABLE ##1 PSEL && PENABLE |=> PREADY)
        else $error("apb access not answered");
endmodule : link_fault_propagation

// ==== sim/link_peer.sv ====
`timescale 1ns/1ps
// ==========================================================
// far side: peer converter and copper end device
module link_peer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // faults commanded by the bench
    input wire logic cut_fiber,
    input wire logic cut_rx,
    input wire logic cut_copper,
    // fault levels seen by the converter
    output logic fiber_fault,
    output logic fiber_rx_fault,
    output logic copper_fault
);
    // peer keeps its own echo off, so no lock-up loop
    // peer forwards faults both ways as plain levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fiber_fault <= 1'b0;
            fiber_rx_fault <= 1'b0;
            copper_fault <= 1'b0;
        end else begin
            fiber_fault <= cut_fiber;
            fiber_rx_fault <= cut_rx;
            copper_fault <= cut_copper;
        end
    end
endmodule : link_peer

// ==== sim/link_fault_propagation_test.sv ====
`timescale 1ns/1ps
module link_fault_propagation_test;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic ff, rx, cf, cut_f, cut_r, cut_c, cen, txen, lled, fled, e;
    int failures = 0;
    int total_checks = 0;
    // ctrl, fiber, rx, copper faults -> copper en, tx en, link led
    logic [9:0] cases [7] = '{10'b0000_100_110, 10'b0001_100_010,
        10'b0010_001_101, 10'b1010_001_100, 10'b0100_010_100,
        10'b0000_010_110, 10'b0011_101_000};
    link_peer link_peer_i (.clk(clk), .rst(rst), .cut_fiber(cut_f),
        .cut_rx(cut_r), .cut_copper(cut_c), .fiber_fault(ff),
        .fiber_rx_fault(rx), .copper_fault(cf));
    link_fault_propagation link_fault_propagation_i (.CLK(clk), .RST(rst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .FIBER_FAULT(ff), .FIBER_RX_FAULT(rx),
        .COPPER_FAULT(cf), .COPPER_LINK_EN(cen), .FIBER_TX_EN(txen),
        .FIBER_LINK_LED(lled), .FIBER_FAULT_LED(fled), .IRQ(irq));
    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // slave latency is not assumed; the wait ends on pready, or after 20 cycles with a failure
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            give_verdict();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic settle();
        repeat (5) @(posedge clk);
    endtask : settle
    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    // ==========================================================
    // clock, reset, watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #(50 * 5000);
        failures++;
        give_verdict();
    end
    // ==========================================================
    // tests
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cut_f, cut_r, cut_c} = 3'b000;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1 chk({cen, txen, irq}, 3'b110);
        apb(1'b0, lfp_pkg::OFF_BAUD, 32'h0);
        chk(q, 32'h0810_9600);
        apb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        // every case also checks recovery, a stuck output shows here
        foreach (cases[i]) begin
            apb(1'b1, lfp_pkg::OFF_CTRL, {28'h0, cases[i][9:6]});
            {cut_f, cut_r, cut_c} <= cases[i][5:3];
            settle();
            chk({cen, txen, lled}, cases[i][2:0]);
            chk(fled, cases[i][5] | cases[i][4]);
            {cut_f, cut_r, cut_c} <= 3'b000;
            settle();
            chk({cen, txen, lled, fled}, 4'b1110);
        end
        apb(1'b1, lfp_pkg::OFF_IRQ_STAT, 32'hf);
        apb(1'b1, lfp_pkg::OFF_IRQ_MASK, 32'h2);
        cut_c <= 1'b1;
        settle();
        chk(irq, 1'b1);
        apb(1'b0, lfp_pkg::OFF_STATUS, 32'h0);
        chk(q, 32'h6);
        apb(1'b1, lfp_pkg::OFF_IRQ_STAT, 32'h2);
        settle();
        chk(irq, 1'b0);
        cut_c <= 1'b0;
        settle();
        apb(1'b0, lfp_pkg::OFF_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        chk(q, 32'h8);
        give_verdict();
    end
endmodule : link_fault_propagation_test
